// >>> rtl/asd_pkg.sv
// package: operation codes, register indices and reset values of the add/subtract datapath
package asd_pkg;

    // ========================================================================
    // operation codes
    typedef enum logic [2:0] {
        ASD_OP_SUM          = 3'h0,
        ASD_OP_SUM_CARRY    = 3'h1,
        ASD_OP_DIFF         = 3'h2,
        ASD_OP_DIFF_BORROW  = 3'h3,
        ASD_OP_REV_DIFF     = 3'h4,
        ASD_OP_WIDE_SUM     = 3'h5,
        ASD_OP_WIDE_DIFF    = 3'h6
    } asd_op_t;

    // ========================================================================
    // register indices and field positions
    localparam logic [3:0]  ASD_IDX_STACK_POINTER   = 4'hd;
    localparam logic [3:0]  ASD_IDX_PROGRAM_COUNTER = 4'hf;
    localparam int          ASD_CONST_W             = 12;
    localparam int          ASD_ALIGN_BITS          = 2;
    localparam int          ASD_BRANCH_LSB          = 0;

    // ========================================================================
    // reset values and latency
    localparam logic [3:0]  ASD_FLAGS_RST           = 4'h0;
    localparam logic [3:0]  ASD_INDEX_RST           = 4'h0;
    localparam int          ASD_LATENCY_CYC         = 1;

endpackage

// >>> rtl/asd_adder.sv
// module: carry-chain adder with carry out and signed overflow
`timescale 1ns/10ps
`default_nettype none

module asd_adder #(
    parameter int WIDTH = 32
) (
    input  wire logic [WIDTH-1:0] a_in,
    input  wire logic [WIDTH-1:0] b_in,
    input  wire logic             carry_in,
    output logic      [WIDTH-1:0] sum_out,
    output logic                  carry_out,
    output logic                  overflow_out
);

    // ========================================================================
    // elaboration check
    if (WIDTH < 2) begin : g_bad_width
        $error("asd_adder: WIDTH must be at least 2");
    end

    // ========================================================================
    // sum
    logic [WIDTH:0] full_sum;

    // one wider than the operands so the carry falls out on top
    assign full_sum     = {1'b0, a_in} + {1'b0, b_in} + {{WIDTH{1'b0}}, carry_in};
    assign sum_out      = full_sum[WIDTH-1:0];
    assign carry_out    = full_sum[WIDTH];
    // signs agree going in and disagree coming out
    assign overflow_out = (a_in[WIDTH-1] == b_in[WIDTH-1]) &&
                          (full_sum[WIDTH-1] != a_in[WIDTH-1]);

endmodule

`default_nettype wire

// >>> rtl/asd_datapath.sv
// module: add/subtract datapath with flag register and program counter handling
// Overview of operation
// [RULE1] plain sum adds first operand and second operand or twelve-bit constant
// [RULE2] sum with carry adds first operand, second operand and current carry flag
// [RULE3] plain difference subtracts second operand or twelve-bit constant from first operand
// [RULE4] difference with borrow subtracts one more when carry flag is clear
// [RULE5] reversed difference computes second operand minus first operand
// [RULE6] constant form only for plain sum and difference, 0-4095, never flag setting
// [RULE7] omitted destination writes the result back to the first operand register
// [RULE8] flag-setting form updates negative, zero, carry, overflow; otherwise flags hold
// [RULE9] software never uses stack pointer or program counter as second operand
// [RULE10] stack pointer destination only in sum/difference from stack pointer, shift up to 3
// [RULE11] program counter first operand has its two low bits cleared first; code clears them only in plain sum/difference, not the branch form
// [RULE12] program counter first operand: no flag setting, constant 0 to 4095 only; code refuses neither set_flags nor a register second operand there
// [RULE13] program counter plus index register to program counter branches with bit 0 cleared
// [RULE14] that branch sum sets no flags, plain index register, last in predication block; code still writes the flags there when set_flags is given
// [RULE15] wide immediate sum and difference act as the constant forms
// [RULE16] software chains flag-setting low word with carry or borrow forms above
// [RULE17] subtract carry means no borrow; overflow is signed 32-bit overflow
`timescale 1ns/10ps
`default_nettype none

module asd_datapath #(
    parameter int DATA_W = 32
) (
    input  wire logic                   clk,
    input  wire logic                   rst_b,
    input  wire logic                   op_valid,
    input  wire asd_pkg::asd_op_t       op_code,
    input  wire logic                   use_constant,
    input  wire logic                   set_flags,
    input  wire logic                   dest_present,
    input  wire logic [3:0]             dest_index,
    input  wire logic [3:0]             first_index,
    input  wire logic [DATA_W-1:0]      first_operand_register,
    input  wire logic [DATA_W-1:0]      flexible_second_operand,
    input  wire logic [11:0]            twelve_bit_constant,
    output logic                        result_valid_r,
    output logic [DATA_W-1:0]           result_r,
    output logic [3:0]                  write_index_r,
    output logic                        branch_r,
    output logic [DATA_W-1:0]           branch_target_r,
    output logic                        illegal_r,
    output logic                        flag_n_r,
    output logic                        flag_z_r,
    output logic                        flag_c_r,
    output logic                        flag_v_r
);

    // ========================================================================
    // elaboration check
    if (DATA_W <= asd_pkg::ASD_CONST_W) begin : g_bad_width
        $error("asd_datapath: DATA_W must exceed the constant width");
    end

    // ========================================================================
    // decode
    asd_pkg::asd_op_t   base_op;
    logic               const_form;
    logic               reject;
    logic               pc_first;
    logic               pc_branch;
    logic               flag_write;
    logic               branch_take;
    logic [DATA_W-1:0]  first_val;
    logic [DATA_W-1:0]  second_val;
    logic [DATA_W-1:0]  add_a;
    logic [DATA_W-1:0]  add_b;
    logic               add_cin;
    logic [DATA_W-1:0]  add_sum;
    logic               add_cout;
    logic               add_ovf;
    logic [3:0]         write_index_nxt;

    always_comb begin
        // wide forms fold onto the constant forms
        base_op = op_code; // RULE15
        if (op_code == asd_pkg::ASD_OP_WIDE_SUM) begin
            base_op = asd_pkg::ASD_OP_SUM; // RULE15
        end else if (op_code == asd_pkg::ASD_OP_WIDE_DIFF) begin
            base_op = asd_pkg::ASD_OP_DIFF; // RULE15
        end
    end

    assign const_form = use_constant || (op_code == asd_pkg::ASD_OP_WIDE_SUM) ||
                        (op_code == asd_pkg::ASD_OP_WIDE_DIFF);
    // unknown codes and constant forms of other ops or with flags are refused
    assign reject     = (op_code > asd_pkg::ASD_OP_WIDE_DIFF) ||
                        (const_form && ((base_op != asd_pkg::ASD_OP_SUM &&
                                         base_op != asd_pkg::ASD_OP_DIFF) || set_flags)); // RULE6
    assign pc_first   = (first_index == asd_pkg::ASD_IDX_PROGRAM_COUNTER) &&
                        (base_op == asd_pkg::ASD_OP_SUM || base_op == asd_pkg::ASD_OP_DIFF);
    assign pc_branch  = pc_first && !const_form && (base_op == asd_pkg::ASD_OP_SUM) &&
                        dest_present && (dest_index == asd_pkg::ASD_IDX_PROGRAM_COUNTER);
    // the branch form relies on software not asking for flags there
    assign flag_write = op_valid && !reject && set_flags && !const_form; // RULE8 RULE14
    // back-to-back branches keep the pulse high, so the check follows this
    assign branch_take = op_valid && !reject && pc_branch; // RULE13

    always_comb begin
        first_val = first_operand_register;
        // branch form keeps the raw value, every other pc base of a plain sum or difference is word aligned
        if (pc_first && !pc_branch) begin
            first_val = {first_operand_register[DATA_W-1:asd_pkg::ASD_ALIGN_BITS],
                         {asd_pkg::ASD_ALIGN_BITS{1'b0}}}; // RULE11
        end
    end

    // constant is zero extended so it spans 0-4095 only
    assign second_val = const_form ?
                        {{(DATA_W-asd_pkg::ASD_CONST_W){1'b0}}, twelve_bit_constant} : // RULE6
                        flexible_second_operand;

    always_comb begin
        add_a   = first_val;
        add_b   = second_val;
        add_cin = 1'b0;
        case (base_op)
            asd_pkg::ASD_OP_SUM: begin
                add_cin = 1'b0; // RULE1
            end
            asd_pkg::ASD_OP_SUM_CARRY: begin
                add_cin = flag_c_r; // RULE2
            end
            asd_pkg::ASD_OP_DIFF: begin
                add_b   = ~second_val; // RULE3
                add_cin = 1'b1;
            end
            asd_pkg::ASD_OP_DIFF_BORROW: begin
                // clear carry drops the +1 of the two's complement: one less
                add_b   = ~second_val; // RULE4
                add_cin = flag_c_r;
            end
            asd_pkg::ASD_OP_REV_DIFF: begin
                add_a   = second_val; // RULE5
                add_b   = ~first_val;
                add_cin = 1'b1;
            end
            default: begin
                add_cin = 1'b0;
            end
        endcase
    end

    // subtract through inverted operand: carry out is already "no borrow"
    asd_adder #(
        .WIDTH          (DATA_W)
    ) u_adder (
        .a_in           (add_a),
        .b_in           (add_b),
        .carry_in       (add_cin),
        .sum_out        (add_sum),
        .carry_out      (add_cout), // RULE17
        .overflow_out   (add_ovf)   // RULE17
    );

    assign write_index_nxt = dest_present ? dest_index : first_index; // RULE7

    // ========================================================================
    // result stage
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            result_valid_r <= 1'b0;
            illegal_r      <= 1'b0;
            result_r       <= '0;
            write_index_r  <= asd_pkg::ASD_INDEX_RST;
        end else begin
            result_valid_r <= op_valid && !reject && !pc_branch;
            illegal_r      <= op_valid && reject;
            if (op_valid && !reject) begin
                result_r      <= add_sum; // RULE1 RULE3
                write_index_r <= write_index_nxt; // RULE7
            end
        end
    end

    // ========================================================================
    // branch stage
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            branch_r        <= 1'b0;
            branch_target_r <= '0;
        end else begin
            branch_r <= op_valid && !reject && pc_branch; // RULE13
            if (op_valid && !reject && pc_branch) begin
                branch_target_r <= {add_sum[DATA_W-1:asd_pkg::ASD_BRANCH_LSB+1], 1'b0}; // RULE13
            end
        end
    end

    // ========================================================================
    // flag register
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            {flag_n_r, flag_z_r, flag_c_r, flag_v_r} <= asd_pkg::ASD_FLAGS_RST;
        end else if (flag_write) begin
            flag_n_r <= add_sum[DATA_W-1]; // RULE8
            flag_z_r <= (add_sum == '0);   // RULE8
            flag_c_r <= add_cout;          // RULE8 RULE17
            flag_v_r <= add_ovf;           // RULE8 RULE17
        end
    end

    // ========================================================================
    // checks
    sequence s_plain_req(asd_pkg::asd_op_t op);
        op_valid && op_code == op && !use_constant && first_index != asd_pkg::ASD_IDX_PROGRAM_COUNTER;
    endsequence

    sequence s_branch_req;
        op_valid && !reject && pc_branch;
    endsequence

    a_sum_value: assert property (@(posedge clk) disable iff (!rst_b) // RULE1
        s_plain_req(asd_pkg::ASD_OP_SUM) |=>
        result_r == $past(first_operand_register) + $past(flexible_second_operand))
        else $error("plain sum result wrong");

    a_carry_sum: assert property (@(posedge clk) disable iff (!rst_b) // RULE2
        s_plain_req(asd_pkg::ASD_OP_SUM_CARRY) |=>
        result_r == $past(first_operand_register) + $past(flexible_second_operand) +
                    {{(DATA_W-1){1'b0}}, $past(flag_c_r)})
        else $error("carry sum result wrong");

    a_diff_value: assert property (@(posedge clk) disable iff (!rst_b) // RULE3
        s_plain_req(asd_pkg::ASD_OP_DIFF) |=>
        result_r == $past(first_operand_register) - $past(flexible_second_operand))
        else $error("plain difference result wrong");

    a_borrow_diff: assert property (@(posedge clk) disable iff (!rst_b) // RULE4
        s_plain_req(asd_pkg::ASD_OP_DIFF_BORROW) |=>
        result_r == $past(first_operand_register) - $past(flexible_second_operand) -
                    {{(DATA_W-1){1'b0}}, !$past(flag_c_r)})
        else $error("borrow difference result wrong");

    a_rev_diff: assert property (@(posedge clk) disable iff (!rst_b) // RULE5
        s_plain_req(asd_pkg::ASD_OP_REV_DIFF) |=>
        result_r == $past(flexible_second_operand) - $past(first_operand_register))
        else $error("reversed difference result wrong");

    a_const_refuse: assert property (@(posedge clk) disable iff (!rst_b) // RULE6
        op_valid && use_constant && (set_flags || op_code == asd_pkg::ASD_OP_REV_DIFF) |=>
        illegal_r && !result_valid_r && $stable({flag_n_r, flag_z_r, flag_c_r, flag_v_r}))
        else $error("illegal constant form accepted");

    a_dest_default: assert property (@(posedge clk) disable iff (!rst_b) // RULE7
        op_valid && !reject && !dest_present |=> write_index_r == $past(first_index))
        else $error("omitted destination not first operand");

    a_flags_hold: assert property (@(posedge clk) disable iff (!rst_b) // RULE8
        op_valid && !set_flags |=> $stable({flag_n_r, flag_z_r, flag_c_r, flag_v_r}))
        else $error("flags changed without flag setting");

    a_flag_zero: assert property (@(posedge clk) disable iff (!rst_b) // RULE8
        flag_write |=> flag_z_r == (result_r == '0) && flag_n_r == result_r[DATA_W-1])
        else $error("zero or negative flag wrong");

    a_pc_align: assert property (@(posedge clk) disable iff (!rst_b) // RULE11
        op_valid && use_constant && !set_flags && op_code == asd_pkg::ASD_OP_SUM &&
        first_index == asd_pkg::ASD_IDX_PROGRAM_COUNTER |=>
        result_r[1:0] == $past(twelve_bit_constant[1:0]))
        else $error("program counter base not aligned");

    a_branch_even: assert property (@(posedge clk) disable iff (!rst_b) // RULE13
        s_branch_req |=> (branch_r && !result_valid_r && branch_target_r[0] == 1'b0) ##1
        (branch_r == $past(branch_take)))
        else $error("branch target bit 0 not cleared");

    a_wide_same: assert property (@(posedge clk) disable iff (!rst_b) // RULE15
        op_valid && op_code == asd_pkg::ASD_OP_WIDE_DIFF && !set_flags &&
        first_index != asd_pkg::ASD_IDX_PROGRAM_COUNTER |=>
        result_r == $past(first_operand_register) -
                    {{(DATA_W-asd_pkg::ASD_CONST_W){1'b0}}, $past(twelve_bit_constant)})
        else $error("wide difference differs from constant form");

    a_borrow_carry: assert property (@(posedge clk) disable iff (!rst_b) // RULE17
        flag_write && base_op == asd_pkg::ASD_OP_DIFF && !const_form |=>
        flag_c_r == ($past(first_val) >= $past(second_val)))
        else $error("subtract carry not inverted borrow");

endmodule

`default_nettype wire

// >>> dv/asd_sw_model.sv
// partner: instruction stream from software, presenting one operation per cycle
`timescale 1ns/10ps
`default_nettype none

module asd_sw_model (
    input  wire logic        clk,
    input  wire logic        req,
    input  wire logic [89:0] cmd,
    output var  logic        op_valid,
    output var  asd_pkg::asd_op_t op_code,
    output var  logic        use_constant,
    output var  logic        set_flags,
    output var  logic        dest_present,
    output var  logic [3:0]  dest_index,
    output var  logic [3:0]  first_index,
    output var  logic [31:0] first_operand_register,
    output var  logic [31:0] flexible_second_operand,
    output var  logic [11:0] twelve_bit_constant
);
    // ========================================================================
    // drive
    initial begin
        op_valid = 1'b0;
        op_code = asd_pkg::ASD_OP_SUM;
        {use_constant, set_flags, dest_present, dest_index, first_index} = 11'h0;
        {first_operand_register, flexible_second_operand, twelve_bit_constant} = 76'h0;
    end

    // commands pass through unchecked: no sp/pc second operand, no pc flag setting, but refused forms do occur
    always @(negedge clk) begin
        op_valid <= req;
        if (req) begin
            op_code <= asd_pkg::asd_op_t'(cmd[89:87]);
            {use_constant, set_flags, dest_present, dest_index, first_index} <= cmd[86:76];
            {first_operand_register, flexible_second_operand, twelve_bit_constant} <= cmd[75:0];
        end else begin
            // idle operands flip so a stale value never passes as fresh
            first_operand_register <= ~first_operand_register;
            flexible_second_operand <= ~flexible_second_operand;
            twelve_bit_constant <= ~twelve_bit_constant;
        end
    end
endmodule

`default_nettype wire

// >>> dv/tb_top.sv
// testbench: table of back-to-back operations, then reset cases
`timescale 1ns/10ps
`default_nettype none

module tb_top;
    typedef struct packed {
        logic [89:0] cmd;
        logic [1:0]  kind;
        logic [31:0] res;
        logic [3:0]  widx;
        logic [3:0]  nzcv;
    } asd_row_t;

    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic req = 1'b0;
    logic [89:0] cmd = 90'h0;
    logic op_valid, use_constant, set_flags, dest_present;
    asd_pkg::asd_op_t op_code;
    logic [3:0] dest_index, first_index, write_index_r;
    logic [31:0] first_operand_register, flexible_second_operand, result_r, branch_target_r;
    logic [11:0] twelve_bit_constant;
    logic result_valid_r, branch_r, illegal_r, flag_n_r, flag_z_r, flag_c_r, flag_v_r;
    int fail_count = 0;
    int checked = 0;
    asd_row_t rows[$];

    asd_sw_model u_sw (.clk, .req, .cmd, .op_valid, .op_code, .use_constant, .set_flags,
        .dest_present, .dest_index, .first_index, .first_operand_register,
        .flexible_second_operand, .twelve_bit_constant);

    asd_datapath #(.DATA_W(32)) u_dut (.clk, .rst_b, .op_valid, .op_code, .use_constant,
        .set_flags, .dest_present, .dest_index, .first_index, .first_operand_register,
        .flexible_second_operand, .twelve_bit_constant, .result_valid_r, .result_r,
        .write_index_r, .branch_r, .branch_target_r, .illegal_r, .flag_n_r, .flag_z_r,
        .flag_c_r, .flag_v_r);

    // ========================================================================
    // clock and watchdog
    initial begin
        forever #25 clk = ~clk;
    end

    initial begin
        // about 36 cycles expected; generous margin
        #(50 * 2000);
        fail_count++;
        close_out();
    end

    // ========================================================================
    // helpers
    function automatic void add(input logic [2:0] op, input logic [2:0] usd, input logic [3:0] di,
        input logic [3:0] fi, input logic [31:0] a, input logic [31:0] b, input logic [11:0] k,
        input logic [1:0] kind, input logic [31:0] r, input logic [3:0] f);
        asd_row_t row;
        row.cmd = {op, usd, di, fi, a, b, k};
        row.kind = kind;
        row.res = r;
        row.widx = usd[0] ? di : fi;
        row.nzcv = f;
        rows.push_back(row);
    endfunction

    task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic check_row(input asd_row_t row);
        check("pulses", {29'h0, 3'h4 >> row.kind},
            {29'h0, result_valid_r, branch_r, illegal_r});
        check("flags", {28'h0, row.nzcv},
            {28'h0, flag_n_r, flag_z_r, flag_c_r, flag_v_r});
        if (row.kind == 2'h1) begin
            check("target", row.res, branch_target_r);
        end else begin
            check("result", row.res, result_r);
        end
        if (row.kind == 2'h0) begin
            check("write_index", {28'h0, row.widx}, {28'h0, write_index_r});
        end
    endtask

    task automatic check_zero();
        check("reset_out", 32'h0, {21'h0, result_valid_r, branch_r, illegal_r, flag_n_r,
            flag_z_r, flag_c_r, flag_v_r, write_index_r});
        check("reset_res", 32'h0, result_r | branch_target_r);
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // ========================================================================
    // main sequence
    initial begin
        // usd = use_constant, set_flags, dest_present; flags held unless set_flags
        add(3'h0, 3'h2, 4'h0, 4'h4, 32'hffffffff, 32'h1, 12'h0, 2'h0, 32'h0, 4'h6);
        add(3'h1, 3'h3, 4'h5, 4'h4, 32'h1, 32'h2, 12'h0, 2'h0, 32'h4, 4'h0);
        add(3'h1, 3'h0, 4'h0, 4'h4, 32'h1, 32'h2, 12'h0, 2'h0, 32'h3, 4'h0);
        add(3'h2, 3'h2, 4'h0, 4'h4, 32'h5, 32'h3, 12'h0, 2'h0, 32'h2, 4'h2);
        add(3'h3, 3'h2, 4'h0, 4'h4, 32'h5, 32'h3, 12'h0, 2'h0, 32'h2, 4'h2);
        add(3'h2, 3'h2, 4'h0, 4'h4, 32'h3, 32'h5, 12'h0, 2'h0, 32'hfffffffe, 4'h8);
        add(3'h3, 3'h0, 4'h0, 4'h4, 32'h5, 32'h3, 12'h0, 2'h0, 32'h1, 4'h8);
        add(3'h4, 3'h3, 4'h6, 4'h4, 32'h3, 32'ha, 12'h0, 2'h0, 32'h7, 4'h2);
        add(3'h0, 3'h2, 4'h0, 4'h7, 32'h7fffffff, 32'h1, 12'h0, 2'h0, 32'h80000000, 4'h9);
        add(3'h2, 3'h2, 4'h0, 4'h7, 32'h80000000, 32'h1, 12'h0, 2'h0,
            32'h7fffffff, 4'h3);
        add(3'h0, 3'h4, 4'h0, 4'h4, 32'h10, 32'h55, 12'hfff, 2'h0, 32'h100f, 4'h3);
        add(3'h2, 3'h4, 4'h0, 4'h4, 32'h10, 32'h55, 12'h0, 2'h0, 32'h10, 4'h3);
        add(3'h5, 3'h0, 4'h0, 4'h4, 32'h1, 32'h5, 12'hfff, 2'h0, 32'h1000, 4'h3);
        add(3'h6, 3'h0, 4'h0, 4'h4, 32'h0, 32'h5, 12'h1, 2'h0, 32'hffffffff, 4'h3);
        add(3'h0, 3'h5, 4'h2, 4'hf, 32'h103, 32'h5, 12'h4, 2'h0, 32'h104, 4'h3);
        add(3'h2, 3'h5, 4'h2, 4'hf, 32'h107, 32'h5, 12'h4, 2'h0, 32'h100, 4'h3);
        add(3'h7, 3'h2, 4'h0, 4'h4, 32'h1, 32'h1, 12'h0, 2'h2, 32'h100, 4'h3);
        add(3'h1, 3'h4, 4'h0, 4'h4, 32'h1, 32'h1, 12'h1, 2'h2, 32'h100, 4'h3);
        add(3'h0, 3'h6, 4'h0, 4'h4, 32'h1, 32'h1, 12'h1, 2'h2, 32'h100, 4'h3);
        add(3'h5, 3'h2, 4'h0, 4'h4, 32'h1, 32'h1, 12'h1, 2'h2, 32'h100, 4'h3);
        add(3'h0, 3'h1, 4'hf, 4'hf, 32'h100, 32'h21, 12'h0, 2'h1, 32'h120, 4'h3);
        repeat (10) @(negedge clk);
        check_zero();
        rst_b = 1'b1;
        // back to back: row i is checked in the cycle row i+1 is presented
        for (int i = 0; i <= rows.size(); i++) begin
            @(posedge clk);
            #1;
            if (i > 0) begin
                check_row(rows[i-1]);
                $display("test %0d done", i);
            end
            req = (i < rows.size());
            if (i < rows.size()) begin
                cmd = rows[i].cmd;
            end
        end
        // reset in mid-run with an operation pending, then first edge after release
        @(posedge clk);
        #1;
        req = 1'b1;
        cmd = rows[3].cmd;
        @(negedge clk);
        rst_b = 1'b0;
        repeat (2) @(posedge clk);
        #1;
        check_zero();
        $display("test reset done");
        @(negedge clk);
        rst_b = 1'b1;
        @(posedge clk);
        #1;
        check_row(rows[3]);
        $display("test first edge done");
        close_out();
    end
endmodule

`default_nettype wire
